// >>> hw/s8m_top.sv
// register core, edge capture and output drive of the multiplier
`timescale 1ns/1ps
module s8m_top
    import s8m_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] operand_a,
    input  wire logic [7:0] operand_b,
    input  wire logic       operand_a_clock,
    input  wire logic       operand_b_clock,
    input  wire logic       product_clock,
    input  wire logic       round_request,
    input  wire logic       upper_word_output_disable,
    input  wire logic       lower_word_output_disable,
    output logic      [7:0] upper_product_word,
    output logic            upper_word_oe,
    output logic      [7:0] lower_product_word,
    output logic            lower_word_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] op_a_ff;
    logic [7:0] op_b_ff;
    logic       round_ff;
    logic [7:0] upper_ff;
    logic [7:0] lower_ff;
    logic       a_clk_ff;
    logic       b_clk_ff;
    logic       p_clk_ff;
    logic       or_clk_ff;

    wire        or_clk;
    wire        a_load;
    wire        b_load;
    wire        r_load;
    wire        p_load;
    wire  [7:0] nxt_op_a;
    wire  [7:0] nxt_op_b;
    wire        nxt_round;
    wire  [7:0] nxt_upper;
    wire  [7:0] nxt_lower;

    s8m_if arr_bus ();

    // ------------------------------------------------------------
    // edge detection and load selection
    // ------------------------------------------------------------
    // low idle assumed
    assign or_clk    = operand_a_clock | operand_b_clock;
    assign a_load    = s8m_rise(operand_a_clock, a_clk_ff);
    assign b_load    = s8m_rise(operand_b_clock, b_clk_ff);
    assign p_load    = s8m_rise(product_clock, p_clk_ff);
    assign r_load    = s8m_rise(or_clk, or_clk_ff);
    assign nxt_op_a  = a_load ? operand_a : op_a_ff;
    assign nxt_op_b  = b_load ? operand_b : op_b_ff;
    assign nxt_round = r_load ? round_request : round_ff;
    assign nxt_upper = p_load ? arr_bus.upper_word : upper_ff;
    assign nxt_lower = p_load ? arr_bus.lower_word : lower_ff;

    assign arr_bus.operand_a = op_a_ff;
    assign arr_bus.operand_b = op_b_ff;
    assign arr_bus.round_q   = round_ff;

    // ------------------------------------------------------------
    // multiplier array
    // ------------------------------------------------------------
    s8m_array u_array (
        .bus (arr_bus.array)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_clk_ff  <= 1'b0;
            b_clk_ff  <= 1'b0;
            p_clk_ff  <= 1'b0;
            or_clk_ff <= 1'b0;
        end else if (clk_en) begin
            a_clk_ff  <= operand_a_clock;
            b_clk_ff  <= operand_b_clock;
            p_clk_ff  <= product_clock;
            or_clk_ff <= or_clk;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_a_ff  <= OP_RST;
            op_b_ff  <= OP_RST;
            round_ff <= 1'b0;
            upper_ff <= WORD_RST;
            lower_ff <= WORD_RST;
        end else if (clk_en) begin
            op_a_ff  <= nxt_op_a;
            op_b_ff  <= nxt_op_b;
            round_ff <= nxt_round;
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // two held words
    assign upper_product_word = upper_ff;
    assign lower_product_word = lower_ff;
    assign upper_word_oe      = ~upper_word_output_disable;
    assign lower_word_oe      = ~lower_word_output_disable;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic signed [15:0] chk_prod;
    assign chk_prod = $signed(op_a_ff) * $signed(op_b_ff);

    prod_load_a: assert property (
        (clk_en && p_load && !round_ff &&
         !(op_a_ff == MOST_NEG && op_b_ff == MOST_NEG))
        |=> (upper_product_word[6:0] == $past(chk_prod[UP_HI:UP_LO]) &&
             lower_product_word[6:0] == $past(chk_prod[LO_HI:0])))
        else $error("product word mismatch");

    sign_dup_a: assert property (
        upper_product_word[WORDW-1] == lower_product_word[WORDW-1])
        else $error("word signs differ");

    neg_one_a: assert property (
        (clk_en && p_load && op_a_ff == MOST_NEG && op_b_ff == MOST_NEG)
        |=> (upper_product_word == NEG_ONE_UP &&
             lower_product_word == NEG_ONE_LO))
        else $error("minus one case wrong");

    op_a_load_a: assert property (
        (clk_en && operand_a_clock && !a_clk_ff)
        |=> op_a_ff == $past(operand_a))
        else $error("operand a not loaded");

    op_b_hold_a: assert property (
        (!(clk_en && operand_b_clock && !b_clk_ff)) |=> $stable(op_b_ff))
        else $error("operand b changed without edge");

    round_load_a: assert property (
        (clk_en && or_clk && !or_clk_ff) |=> round_ff == $past(round_request))
        else $error("round not loaded on or edge");

    out_enable_a: assert property (
        upper_word_oe != upper_word_output_disable &&
        lower_word_oe != lower_word_output_disable)
        else $error("output enable wrong");

    round_add_a: assert property (
        (clk_en && p_load && round_ff &&
         !(op_a_ff == MOST_NEG && op_b_ff == MOST_NEG))
        |=> {upper_product_word[6:0], lower_product_word[6:0]} ==
            14'($past(chk_prod) + $signed(ROUND_ADD)))
        else $error("rounded product wrong");

    prod_hold_a: assert property (
        (!(clk_en && p_load)) |=> $stable(upper_product_word) &&
                                 $stable(lower_product_word))
        else $error("product changed without edge");

    op_b_load_a: assert property (
        (clk_en && operand_b_clock && !b_clk_ff)
        |=> op_b_ff == $past(operand_b))
        else $error("operand b not loaded");

    op_a_hold_a: assert property (
        (!(clk_en && operand_a_clock && !a_clk_ff)) |=> $stable(op_a_ff))
        else $error("operand a changed without edge");

    round_hold_a: assert property (
        (!(clk_en && or_clk && !or_clk_ff)) |=> $stable(round_ff))
        else $error("round changed without or edge");

    prod_sign_a: assert property (
        (clk_en && p_load && !round_ff &&
         !(op_a_ff == MOST_NEG && op_b_ff == MOST_NEG))
        |=> (upper_product_word[WORDW-1] == $past(chk_prod[PRODW-1]) &&
             lower_product_word[WORDW-1] == $past(chk_prod[PRODW-1])))
        else $error("product sign wrong");
endmodule : s8m_top

// >>> shared/s8m_pkg.sv
// constants and helpers for the signed 8x8 multiplier
package s8m_pkg;
    localparam int          OPW        = 8;
    localparam int          WORDW      = 8;
    localparam int          PRODW      = 16;
    localparam int          FRAC_SIGN  = 14;
    localparam int          UP_HI      = 13;
    localparam int          UP_LO      = 7;
    localparam int          LO_HI      = 6;
    localparam logic [7:0]  MOST_NEG   = 8'h80;
    localparam logic [15:0] ROUND_ADD  = 16'h0040;
    localparam logic [15:0] NO_ADD     = 16'h0000;
    localparam logic [7:0]  NEG_ONE_UP = 8'h80;
    localparam logic [7:0]  NEG_ONE_LO = 8'h80;
    localparam logic [7:0]  OP_RST     = 8'h00;
    localparam logic [7:0]  WORD_RST   = 8'h00;

    // rising edge of a sampled level
    function automatic logic s8m_rise(input logic now_v, input logic old_v);
        return now_v & ~old_v;
    endfunction : s8m_rise
endpackage : s8m_pkg

// >>> shared/s8m_if.sv
// carrier between the register core and the multiplier array
`timescale 1ns/1ps
interface s8m_if;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
    logic       round_q;
    logic [7:0] upper_word;
    logic [7:0] lower_word;

    modport array (
        input  operand_a,
        input  operand_b,
        input  round_q,
        output upper_word,
        output lower_word
    );
    modport core (
        output operand_a,
        output operand_b,
        output round_q,
        input  upper_word,
        input  lower_word
    );
endinterface : s8m_if

// >>> hw/s8m_array.sv
// asynchronous signed multiplier array with rounding
`timescale 1ns/1ps
module s8m_array
    import s8m_pkg::*;
(
    s8m_if.array bus
);
    wire signed [15:0] full_prod;
    wire               both_neg;
    wire        [15:0] round_term;
    wire        [15:0] rounded;
    wire               product_sign_bit;

    assign full_prod  = $signed(bus.operand_a) * $signed(bus.operand_b);
    assign round_term = bus.round_q ? ROUND_ADD : NO_ADD;
    assign rounded    = 16'(full_prod + $signed(round_term));
    assign both_neg   = (bus.operand_a == MOST_NEG) &&
                        (bus.operand_b == MOST_NEG);
    assign product_sign_bit = rounded[FRAC_SIGN];
    assign bus.upper_word = both_neg ? NEG_ONE_UP :
                            {product_sign_bit, rounded[UP_HI:UP_LO]};
    assign bus.lower_word = both_neg ? NEG_ONE_LO :
                            {product_sign_bit, rounded[LO_HI:0]};
endmodule : s8m_array

// >>> testbench/s8m_far.sv
// far-side datapath model driving operands and pin clocks
`timescale 1ns/1ps
module s8m_far
    import s8m_pkg::*;
(
    input  wire logic       sys_clk,
    output logic      [7:0] operand_a,
    output logic      [7:0] operand_b,
    output logic      [2:0] clks,
    output logic            round_request,
    output logic            min_pair
);
    initial begin
        {operand_a, operand_b, clks, round_request} = 20'h00000;
    end

    assign min_pair = (operand_a == MOST_NEG) && (operand_b == MOST_NEG);

    task automatic set(input logic [2:0] c, input logic [7:0] a,
                       input logic [7:0] b, input logic r);
        @(negedge sys_clk);
        {operand_a, operand_b, clks, round_request} = {a, b, c, r};
    endtask : set

    task automatic pulse(input logic [2:0] c, input logic [7:0] a,
                         input logic [7:0] b, input logic r);
        set(c, a, b, r);
        set(3'h0, a, b, r);
    endtask : pulse
endmodule : s8m_far

// >>> testbench/tb.sv
// self-checking bench for the signed 8x8 multiplier
`timescale 1ns/1ps
module tb import s8m_pkg::*; ;
    logic        sys_clk;
    logic        rst;
    logic        clk_en;
    logic        dis_up;
    logic        dis_lo;
    logic  [7:0] oa;
    logic  [7:0] ob;
    logic  [2:0] clks;
    logic        rnd;
    logic        min_pair;
    logic  [7:0] up_w;
    logic  [7:0] lo_w;
    logic        up_oe;
    logic        lo_oe;
    logic [15:0] words;
    int          errors = 0;
    int          num_checks = 0;

    assign words = {up_w, lo_w};
    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    s8m_far far (.sys_clk(sys_clk), .operand_a(oa), .operand_b(ob),
        .clks(clks), .round_request(rnd), .min_pair(min_pair));
    s8m_top uut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .operand_a(oa), .operand_b(ob), .operand_a_clock(clks[0]),
        .operand_b_clock(clks[1]), .product_clock(clks[2]),
        .round_request(rnd), .upper_word_output_disable(dis_up),
        .lower_word_output_disable(dis_lo), .upper_product_word(up_w),
        .upper_word_oe(up_oe), .lower_product_word(lo_w),
        .lower_word_oe(lo_oe));

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [15:0] ex(input logic [7:0] a,
                                       input logic [7:0] b, input logic r);
        logic [15:0] p;
        p = {{8{a[7]}}, a} * {{8{b[7]}}, b};
        if (r)
            p = p + ROUND_ADD;
        if (a == MOST_NEG && b == MOST_NEG)
            return {NEG_ONE_UP, NEG_ONE_LO};
        return {p[14:7], p[14], p[6:0]};
    endfunction : ex

    task automatic prod();
        far.pulse(3'h4, oa, ob, rnd);
        far.set(3'h0, oa, ob, rnd);
    endtask : prod

    task automatic mul(input logic [7:0] a, input logic [7:0] b,
                       input logic r);
        far.pulse(3'h1, a, b, r);
        far.pulse(3'h2, a, b, r);
        prod();
    endtask : mul

    task automatic t_table();
        logic [7:0]  xa [7] = '{8'h7F, 8'h80, 8'h01, 8'h55, 8'hFF, 8'h00,
                                8'h80};
        logic [7:0]  xb [7] = '{8'h7F, 8'h7F, 8'hFF, 8'hC3, 8'hFF, 8'h80,
                                8'h80};
        logic [15:0] e;
        for (int i = 0; i < 7; i++) begin
            e = ex(xa[i], xb[i], 1'b0);
            mul(xa[i], xb[i], 1'b0);
            check("product", words, e);
            check("signs", {up_w[7], lo_w[7]}, {2{e[15]}});
            check("pair", min_pair, i == 6);
        end
        $display("table done");
    endtask : t_table

    task automatic t_round();
        mul(8'h10, 8'h10, 1'b1);
        check("round", words, ex(8'h10, 8'h10, 1'b1));
        mul(8'h80, 8'h80, 1'b1);
        check("round neg", words, {NEG_ONE_UP, NEG_ONE_LO});
        $display("round done");
    endtask : t_round

    task automatic t_or();
        far.pulse(3'h1, 8'h10, 8'h10, 1'b0);
        far.pulse(3'h2, 8'h10, 8'h10, 1'b1);
        prod();
        check("or load", words, ex(8'h10, 8'h10, 1'b1));
        far.set(3'h1, 8'h10, 8'h10, 1'b0);
        far.set(3'h3, 8'h10, 8'h10, 1'b1);
        far.set(3'h0, 8'h10, 8'h10, 1'b1);
        prod();
        check("or hold", words, ex(8'h10, 8'h10, 1'b0));
        $display("or done");
    endtask : t_or

    task automatic t_hold();
        mul(8'h05, 8'h03, 1'b0);
        far.pulse(3'h2, 8'h66, 8'h07, 1'b0);
        check("stand", words, ex(8'h05, 8'h03, 1'b0));
        prod();
        check("held a", words, ex(8'h05, 8'h07, 1'b0));
        $display("hold done");
    endtask : t_hold

    task automatic t_oe();
        logic [1:0] en_exp;
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            {dis_up, dis_lo} = 2'(i);
            en_exp = ~2'(i);
            #1;
            check("oe", {up_oe, lo_oe}, en_exp);
        end
        $display("oe done");
    endtask : t_oe

    task automatic t_freeze();
        mul(8'h05, 8'h03, 1'b0);
        @(negedge sys_clk);
        clk_en = 1'b0;
        far.pulse(3'h3, 8'h11, 8'h22, 1'b1);
        far.pulse(3'h4, 8'h11, 8'h22, 1'b1);
        @(negedge sys_clk);
        clk_en = 1'b1;
        check("frozen", words, ex(8'h05, 8'h03, 1'b0));
        prod();
        check("resume", words, ex(8'h05, 8'h03, 1'b0));
        $display("freeze done");
    endtask : t_freeze

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial begin
        {rst, clk_en, dis_up, dis_lo} = 4'hC;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_table();
        t_round();
        t_or();
        t_hold();
        t_freeze();
        t_oe();
        conclude();
    end

    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule : tb
